// *** gate_drive_cfg_map.vh ***
`ifndef GATE_DRIVE_CFG_MAP_VH
`define GATE_DRIVE_CFG_MAP_VH

// Register offsets on the 6-bit register port
`define ADDR_W                6
`define ADDR_DIAG_CTRL        6'h05
`define ADDR_SRC_CUR_A        6'h06
`define ADDR_SRC_CUR_B        6'h07
`define ADDR_SRC_CUR_C        6'h08

// Reset values
`define RST_DIAG_CTRL         8'h40
`define RST_SRC_CUR           8'hff
`define RDATA_UNMAPPED        8'h00

// Diagnostics control field positions
`define BIT_OT_RECOVERY       7
`define BIT_DLY_HI            6
`define BIT_DLY_LO            5
`define BIT_SHORT_DIAG        4
`define BIT_PASSIVE_OL        3
`define BIT_ACTIVE_OL_C       2
`define BIT_ACTIVE_OL_B       1
`define BIT_ACTIVE_OL_A       0

// Source current nibbles
`define SRC_LOW_HI            7
`define SRC_LOW_LO            4
`define SRC_HIGH_HI           3
`define SRC_HIGH_LO           0

// Delay codes
`define DLY_CODE_0            2'b00
`define DLY_CODE_1            2'b01
`define DLY_CODE_2            2'b10
`define DLY_CODE_3            2'b11

// Clock rate and delays in microseconds, sized to the delay counter
`define CLK_MHZ               19'd40
`define OL_DLY0_US            19'd250
`define OL_DLY1_US            19'd1250
`define OL_DLY2_US            19'd5000
`define OL_DLY3_US            19'd11500
`define SH_DLY0_US            19'd100
`define SH_DLY1_US            19'd500
`define SH_DLY2_US            19'd2000
`define SH_DLY3_US            19'd4400

// Cycle counts derived from rate and time
`define OL_DLY0_CYC           (`OL_DLY0_US * `CLK_MHZ)
`define OL_DLY1_CYC           (`OL_DLY1_US * `CLK_MHZ)
`define OL_DLY2_CYC           (`OL_DLY2_US * `CLK_MHZ)
`define OL_DLY3_CYC           (`OL_DLY3_US * `CLK_MHZ)
`define SH_DLY0_CYC           (`SH_DLY0_US * `CLK_MHZ)
`define SH_DLY1_CYC           (`SH_DLY1_US * `CLK_MHZ)
`define SH_DLY2_CYC           (`SH_DLY2_US * `CLK_MHZ)
`define SH_DLY3_CYC           (`SH_DLY3_US * `CLK_MHZ)
`define DLY_CNT_W             19

// Peak source current in half-milliamp units
`define SRC_MA_W              11

`endif

// *** diag_delay_timer.v ***
`timescale 1ns/1ps
`include "gate_drive_cfg_map.vh"

module diag_delay_timer (
    input  wire                    i_ref_clk,
    input  wire                    i_resetn,
    input  wire                    i_enable,
    input  wire [`DLY_CNT_W-1:0]   i_cycles,
    output reg                     o_done
);

    reg  [`DLY_CNT_W-1:0] count;

    // Dropping the enable restarts the full delay on the next run
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count  <= {`DLY_CNT_W{1'b0}};
            o_done <= 1'b0;
        end else if (!i_enable) begin
            count  <= {`DLY_CNT_W{1'b0}};
            o_done <= 1'b0;
        end else if (count >= i_cycles - {{(`DLY_CNT_W-1){1'b0}}, 1'b1}) begin
            count  <= {`DLY_CNT_W{1'b0}};
            o_done <= 1'b1;
        end else begin
            count  <= count + {{(`DLY_CNT_W-1){1'b0}}, 1'b1};
            o_done <= 1'b0;
        end
    end

endmodule // diag_delay_timer

// *** src_current_decode.v ***
`timescale 1ns/1ps
`include "gate_drive_cfg_map.vh"

module src_current_decode (
    input  wire                  i_ref_clk,
    input  wire                  i_resetn,
    input  wire [3:0]            i_code,
    output reg  [`SRC_MA_W-1:0]  o_half_ma
);

    // Half-milliamp units keep the 1.5 mA step exact
    function [`SRC_MA_W-1:0] code_to_half_ma;
        input [3:0] code;
        begin
            case (code)
                4'h0:    code_to_half_ma = 11'h003;
                4'h1:    code_to_half_ma = 11'h007;
                4'h2:    code_to_half_ma = 11'h00a;
                4'h3:    code_to_half_ma = 11'h014;
                4'h4:    code_to_half_ma = 11'h01e;
                4'h5:    code_to_half_ma = 11'h064;
                4'h6:    code_to_half_ma = 11'h078;
                4'h7:    code_to_half_ma = 11'h082;
                4'h8:    code_to_half_ma = 11'h190;
                4'h9:    code_to_half_ma = 11'h1a4;
                4'ha:    code_to_half_ma = 11'h208;
                4'hb:    code_to_half_ma = 11'h212;
                4'hc:    code_to_half_ma = 11'h5be;
                4'hd:    code_to_half_ma = 11'h640;
                4'he:    code_to_half_ma = 11'h74e;
                default: code_to_half_ma = 11'h7d0;
            endcase
        end
    endfunction

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_half_ma <= 11'h7d0;
        end else begin
            o_half_ma <= code_to_half_ma(i_code);
        end
    end

endmodule // src_current_decode

// *** gate_drive_diag_config_regs.v ***
`timescale 1ns/1ps
`include "gate_drive_cfg_map.vh"

module gate_drive_diag_config_regs #(
    parameter [`DLY_CNT_W-1:0] OL_DLY0_CYC = `OL_DLY0_CYC,
    parameter [`DLY_CNT_W-1:0] OL_DLY1_CYC = `OL_DLY1_CYC,
    parameter [`DLY_CNT_W-1:0] OL_DLY2_CYC = `OL_DLY2_CYC,
    parameter [`DLY_CNT_W-1:0] OL_DLY3_CYC = `OL_DLY3_CYC,
    parameter [`DLY_CNT_W-1:0] SH_DLY1_CYC = `SH_DLY1_CYC,
    parameter [`DLY_CNT_W-1:0] SH_DLY2_CYC = `SH_DLY2_CYC,
    parameter [`DLY_CNT_W-1:0] SH_DLY3_CYC = `SH_DLY3_CYC
) (
    input  wire                  i_ref_clk,
    input  wire                  i_resetn,
    input  wire                  i_wr_en,
    input  wire                  i_rd_en,
    input  wire [`ADDR_W-1:0]    i_addr,
    input  wire [7:0]            i_wdata,
    output reg  [7:0]            o_rdata,
    input  wire                  i_overtemp_pin,
    input  wire                  i_clear_fault,
    input  wire                  i_standby,
    output reg                   o_overtemp_fault,
    output wire                  o_short_diag_active,
    output wire                  o_short_diag_sample,
    output wire                  o_passive_ol_active,
    output wire                  o_passive_ol_done,
    output wire [2:0]            o_active_ol_enable,
    output wire [1:0]            o_diag_delay_select,
    output wire [23:0]           o_src_current_code,
    output wire [65:0]           o_src_current_half_ma
);

    localparam [`DLY_CNT_W-1:0] SH_DLY0_CYC = `SH_DLY0_CYC;
    localparam [7:0]            RST_DIAG    = `RST_DIAG_CTRL;
    localparam [7:0]            RST_SRC     = `RST_SRC_CUR;


    reg                      overtemp_recovery_select;
    reg  [1:0]               diag_delay_select;
    reg                      offline_short_diag_enable;
    reg                      passive_open_load_enable;
    reg                      active_open_load_phase_c;
    reg                      active_open_load_phase_b;
    reg                      active_open_load_phase_a;
    reg  [3:0]               src_current_low_phase_a;
    reg  [3:0]               src_current_high_phase_a;
    reg  [3:0]               src_current_low_phase_b;
    reg  [3:0]               src_current_high_phase_b;
    reg  [3:0]               src_current_low_phase_c;
    reg  [3:0]               src_current_high_phase_c;
    reg  [2:0]               ot_sync;
    reg                      ot_cond;
    reg  [7:0]               next_rdata;
    reg  [`DLY_CNT_W-1:0]    ol_cycles;
    reg  [`DLY_CNT_W-1:0]    sh_cycles;
    wire [7:0]               diag_ctrl;
    wire                     wr_diag;
    wire                     ol_run;
    wire                     sh_run;
    wire                     ol_done;

    // Write strobe for one register offset
    function wr_hit;
        input               wr_en;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] offset;
        begin
            wr_hit = wr_en && (addr == offset);
        end
    endfunction

    assign wr_diag = wr_hit(i_wr_en, i_addr, `ADDR_DIAG_CTRL);

    assign diag_ctrl = {overtemp_recovery_select,
                        diag_delay_select,
                        offline_short_diag_enable,
                        passive_open_load_enable,
                        active_open_load_phase_c,
                        active_open_load_phase_b,
                        active_open_load_phase_a};

    // Diagnostics control bits apart from the self-clearing one
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            overtemp_recovery_select  <= RST_DIAG[`BIT_OT_RECOVERY];
            diag_delay_select         <= RST_DIAG[`BIT_DLY_HI:`BIT_DLY_LO];
            offline_short_diag_enable <= RST_DIAG[`BIT_SHORT_DIAG];
            active_open_load_phase_c  <= RST_DIAG[`BIT_ACTIVE_OL_C];
            active_open_load_phase_b  <= RST_DIAG[`BIT_ACTIVE_OL_B];
            active_open_load_phase_a  <= RST_DIAG[`BIT_ACTIVE_OL_A];
        end else if (wr_diag) begin
            overtemp_recovery_select  <= i_wdata[`BIT_OT_RECOVERY];
            diag_delay_select         <= i_wdata[`BIT_DLY_HI:`BIT_DLY_LO];
            offline_short_diag_enable <= i_wdata[`BIT_SHORT_DIAG];
            active_open_load_phase_c  <= i_wdata[`BIT_ACTIVE_OL_C];
            active_open_load_phase_b  <= i_wdata[`BIT_ACTIVE_OL_B];
            active_open_load_phase_a  <= i_wdata[`BIT_ACTIVE_OL_A];
        end
    end

    // Self-clear loses to a write of 1, so a fresh start is never lost
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            passive_open_load_enable <= RST_DIAG[`BIT_PASSIVE_OL];
        end else if (wr_diag && i_wdata[`BIT_PASSIVE_OL]) begin
            passive_open_load_enable <= 1'b1;
        end else if (ol_done) begin
            passive_open_load_enable <= 1'b0;
        end else if (wr_diag) begin
            passive_open_load_enable <= 1'b0;
        end
    end

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_current_low_phase_a  <= RST_SRC[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_a <= RST_SRC[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end else if (wr_hit(i_wr_en, i_addr, `ADDR_SRC_CUR_A)) begin
            src_current_low_phase_a  <= i_wdata[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_a <= i_wdata[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end
    end

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_current_low_phase_b  <= RST_SRC[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_b <= RST_SRC[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end else if (wr_hit(i_wr_en, i_addr, `ADDR_SRC_CUR_B)) begin
            src_current_low_phase_b  <= i_wdata[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_b <= i_wdata[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end
    end

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_current_low_phase_c  <= RST_SRC[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_c <= RST_SRC[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end else if (wr_hit(i_wr_en, i_addr, `ADDR_SRC_CUR_C)) begin
            src_current_low_phase_c  <= i_wdata[`SRC_LOW_HI:`SRC_LOW_LO];
            src_current_high_phase_c <= i_wdata[`SRC_HIGH_HI:`SRC_HIGH_LO];
        end
    end

    // Read mux; unmapped offsets answer zero
    always @* begin
        case (i_addr)
            `ADDR_DIAG_CTRL: next_rdata = diag_ctrl;
            `ADDR_SRC_CUR_A: next_rdata = {src_current_low_phase_a, src_current_high_phase_a};
            `ADDR_SRC_CUR_B: next_rdata = {src_current_low_phase_b, src_current_high_phase_b};
            `ADDR_SRC_CUR_C: next_rdata = {src_current_low_phase_c, src_current_high_phase_c};
            default:         next_rdata = `RDATA_UNMAPPED;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= `RDATA_UNMAPPED;
        end else if (i_rd_en) begin
            o_rdata <= next_rdata;
        end
    end

    // Overtemperature pin is analog-side, so three flops before use
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ot_sync <= 3'h0;
            ot_cond <= 1'b0;
        end else begin
            ot_sync <= {ot_sync[1:0], i_overtemp_pin};
            if (ot_sync[1] == ot_sync[2]) begin
                ot_cond <= ot_sync[2];
            end
        end
    end

    // Condition present always sets, so a clear cannot hide a live fault
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_overtemp_fault <= 1'b0;
        end else if (ot_cond) begin
            o_overtemp_fault <= 1'b1;
        end else if (overtemp_recovery_select) begin
            o_overtemp_fault <= 1'b0;
        end else if (i_clear_fault) begin
            o_overtemp_fault <= 1'b0;
        end
    end

    // Delay selection for both diagnostics
    always @* begin
        case (diag_delay_select)
            `DLY_CODE_0: begin
                ol_cycles = OL_DLY0_CYC;
                sh_cycles = SH_DLY0_CYC;
            end
            `DLY_CODE_1: begin
                ol_cycles = OL_DLY1_CYC;
                sh_cycles = SH_DLY1_CYC;
            end
            `DLY_CODE_2: begin
                ol_cycles = OL_DLY2_CYC;
                sh_cycles = SH_DLY2_CYC;
            end
            default: begin
                ol_cycles = OL_DLY3_CYC;
                sh_cycles = SH_DLY3_CYC;
            end
        endcase
    end

    // Leaving standby aborts the test; it restarts in full on return
    assign ol_run = passive_open_load_enable && i_standby;
    assign sh_run = offline_short_diag_enable && i_standby;

    diag_delay_timer u_ol_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_enable  (ol_run),
        .i_cycles  (ol_cycles),
        .o_done    (ol_done)
    );

    // Short test samples once per delay period while enabled
    diag_delay_timer u_sh_timer (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_enable  (sh_run),
        .i_cycles  (sh_cycles),
        .o_done    (o_short_diag_sample)
    );

    assign o_passive_ol_active = ol_run;
    assign o_passive_ol_done   = ol_done;
    assign o_short_diag_active = sh_run;
    assign o_diag_delay_select = diag_delay_select;
    assign o_active_ol_enable  = {active_open_load_phase_c,
                                  active_open_load_phase_b,
                                  active_open_load_phase_a};

    // Code order: a-low, a-high, b-low, b-high, c-low, c-high from the top
    assign o_src_current_code = {src_current_low_phase_a,
                                 src_current_high_phase_a,
                                 src_current_low_phase_b,
                                 src_current_high_phase_b,
                                 src_current_low_phase_c,
                                 src_current_high_phase_c};

    // One decoder per nibble, slices in the same order as the code bus
    src_current_decode u_dec_a_low (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_low_phase_a),
        .o_half_ma (o_src_current_half_ma[65:55])
    );

    src_current_decode u_dec_a_high (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_high_phase_a),
        .o_half_ma (o_src_current_half_ma[54:44])
    );

    src_current_decode u_dec_b_low (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_low_phase_b),
        .o_half_ma (o_src_current_half_ma[43:33])
    );

    src_current_decode u_dec_b_high (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_high_phase_b),
        .o_half_ma (o_src_current_half_ma[32:22])
    );

    src_current_decode u_dec_c_low (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_low_phase_c),
        .o_half_ma (o_src_current_half_ma[21:11])
    );

    src_current_decode u_dec_c_high (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_code    (src_current_high_phase_c),
        .o_half_ma (o_src_current_half_ma[10:0])
    );

endmodule // gate_drive_diag_config_regs

// *** gate_drive_diag_config_regs_checker.sv ***
`timescale 1ns/1ps
module gate_drive_diag_config_regs_checker #(
    parameter int OL_DLY0_CYC = 32'h14,
    parameter int OL_DLY1_CYC = 32'h28,
    parameter int OL_DLY2_CYC = 32'h3c,
    parameter int OL_DLY3_CYC = 32'h50
) (
    input logic        i_ref_clk,
    input logic        i_resetn,
    input logic        i_wr_en,
    input logic        i_rd_en,
    input logic [5:0]  i_addr,
    input logic [7:0]  i_wdata,
    input logic [7:0]  o_rdata,
    input logic        i_overtemp_pin,
    input logic        i_clear_fault,
    input logic        i_standby,
    input logic        o_overtemp_fault,
    input logic        o_short_diag_active,
    input logic        o_passive_ol_active,
    input logic        o_passive_ol_done,
    input logic [2:0]  o_active_ol_enable,
    input logic [1:0]  o_diag_delay_select,
    input logic [23:0] o_src_current_code
);
    localparam int OLS [4] = '{OL_DLY0_CYC, OL_DLY1_CYC, OL_DLY2_CYC, OL_DLY3_CYC};
    logic       ot_mode;
    logic [7:0] run_cnt;
    logic       diag_wr;
    assign diag_wr = i_wr_en && i_addr == 6'h05;
    // Mode is not a port, so it is mirrored from the write stream
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ot_mode <= 1'b0;
            run_cnt <= 8'h00;
        end else begin
            ot_mode <= diag_wr ? i_wdata[7] : ot_mode;
            run_cnt <= o_passive_ol_active ? run_cnt + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_ol_arm; (diag_wr && i_wdata[3]) ##1 i_standby; endsequence
    sequence s_cool; (ot_mode && !i_overtemp_pin)[*8]; endsequence
    chk_ot_latch: assert property (!ot_mode && o_overtemp_fault && !i_clear_fault
        |=> o_overtemp_fault) else $error("Latched fault dropped");
    chk_ot_recover: assert property (s_cool |=> !o_overtemp_fault)
        else $error("Fault held in recovery mode");
    chk_ol_start: assert property (s_ol_arm |-> o_passive_ol_active)
        else $error("Open-load test not started");
    chk_diag_idle: assert property (!i_standby
        |-> (!o_passive_ol_active && !o_short_diag_active) ##1 !o_passive_ol_done)
        else $error("Test outside standby");
    chk_ol_delay: assert property (o_passive_ol_done
        |-> run_cnt == OLS[o_diag_delay_select]) else $error("Open-load delay wrong");
    chk_ol_selfclr: assert property (o_passive_ol_done && !(diag_wr && i_wdata[3])
        |=> !o_passive_ol_active) else $error("Open-load enable not cleared");
    chk_dly_field: assert property (diag_wr
        |=> o_diag_delay_select == $past(i_wdata[6:5])) else $error("Delay field wrong");
    chk_ola_field: assert property (diag_wr
        |=> o_active_ol_enable == $past(i_wdata[2:0])) else $error("Phase enables wrong");
    chk_cur_a: assert property (i_wr_en && i_addr == 6'h06
        |=> o_src_current_code[23:16] == $past(i_wdata)) else $error("Phase A code wrong");
    chk_rd_unmap: assert property (i_rd_en && (i_addr < 6'h05 || i_addr > 6'h08)
        |=> o_rdata == 8'h00) else $error("Unmapped read not zero");
endmodule // gate_drive_diag_config_regs_checker
bind gate_drive_diag_config_regs gate_drive_diag_config_regs_checker #(
    .OL_DLY0_CYC(OL_DLY0_CYC), .OL_DLY1_CYC(OL_DLY1_CYC),
    .OL_DLY2_CYC(OL_DLY2_CYC), .OL_DLY3_CYC(OL_DLY3_CYC)
) u_chk (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_overtemp_pin(i_overtemp_pin),
    .i_clear_fault(i_clear_fault), .i_standby(i_standby), .o_overtemp_fault(o_overtemp_fault),
    .o_short_diag_active(o_short_diag_active), .o_passive_ol_active(o_passive_ol_active),
    .o_passive_ol_done(o_passive_ol_done), .o_active_ol_enable(o_active_ol_enable),
    .o_diag_delay_select(o_diag_delay_select), .o_src_current_code(o_src_current_code)
);

// *** gate_drive_host_model.sv ***
`timescale 1ns/1ps
module gate_drive_host_model (
    input  logic       i_ref_clk,
    input  logic [7:0] i_rdata,
    output logic       o_wr_en = 1'b0,
    output logic       o_rd_en = 1'b0,
    output logic [5:0] o_addr = 6'h00,
    output logic [7:0] o_wdata = 8'h00
);
    // Released data shows the inverse so a stale value cannot pass
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        @(negedge i_ref_clk);
        d = i_rdata;
    endtask
    task automatic poll_idle(output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            rd(6'h05, d);
            ok = !d[3];
        end
    endtask
endmodule // gate_drive_host_model

// *** test_gate_drive_diag_config_regs.sv ***
`timescale 1ns/1ps
module test_gate_drive_diag_config_regs;
    localparam int OLC [4] = '{32'h14, 32'h28, 32'h3c, 32'h50};
    localparam int SHC [4] = '{32'hfa0, 32'h0a, 32'h0c, 32'h0e};
    localparam logic [10:0] MA [16] = '{11'h003, 11'h007, 11'h00a, 11'h014, 11'h01e, 11'h064,
        11'h078, 11'h082, 11'h190, 11'h1a4, 11'h208, 11'h212, 11'h5be, 11'h640, 11'h74e, 11'h7d0};
    logic        i_ref_clk = 1'b0, i_resetn = 1'b0, i_standby = 1'b0;
    logic        i_overtemp_pin = 1'b0, i_clear_fault = 1'b0;
    logic        wr_en, rd_en, o_overtemp_fault, o_short_diag_sample, o_passive_ol_done, ok;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, rv;
    logic [7:0]  regs [5:8];
    logic [2:0]  o_active_ol_enable;
    logic [1:0]  o_diag_delay_select;
    logic [23:0] o_src_current_code;
    logic [65:0] o_src_current_half_ma;
    logic [31:0] lfsr = 32'h1219;
    int          err_count = 0, n_checks = 0, cnt;
    always #12.5 i_ref_clk = ~i_ref_clk;
    gate_drive_diag_config_regs #(
        .OL_DLY0_CYC(19'(OLC[0])), .OL_DLY1_CYC(19'(OLC[1])), .OL_DLY2_CYC(19'(OLC[2])),
        .OL_DLY3_CYC(19'(OLC[3])), .SH_DLY1_CYC(19'(SHC[1])), .SH_DLY2_CYC(19'(SHC[2])),
        .SH_DLY3_CYC(19'(SHC[3]))
    ) u_dut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_overtemp_pin(i_overtemp_pin),
        .i_clear_fault(i_clear_fault), .i_standby(i_standby),
        .o_overtemp_fault(o_overtemp_fault), .o_short_diag_active(),
        .o_short_diag_sample(o_short_diag_sample), .o_passive_ol_active(),
        .o_passive_ol_done(o_passive_ol_done), .o_active_ol_enable(o_active_ol_enable),
        .o_diag_delay_select(o_diag_delay_select), .o_src_current_code(o_src_current_code),
        .o_src_current_half_ma(o_src_current_half_ma)
    );
    gate_drive_host_model u_host (
        .i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata)
    );
    function automatic logic [65:0] ma_all(input logic [23:0] code);
        logic [65:0] r;
        for (int g = 0; g < 6; g++)
            r[11*g +: 11] = MA[code[4*g +: 4]];
        return r;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cycles up to the next pulse; the bound cuts a hung test short
    task automatic cycles_to(input logic sel, output int n);
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (!(sel ? o_short_diag_sample : o_passive_ol_done) && n < 5000);
        if (n >= 5000) begin
            err_count++;
            report_and_stop;
        end
    endtask
    task automatic check_all;
        for (int a = 5; a <= 8; a++) begin
            u_host.rd(6'(a), rv);
            chk(rv, regs[a]);
        end
        chk(o_src_current_code, {regs[6], regs[7], regs[8]});
        chk(o_src_current_half_ma, ma_all({regs[6], regs[7], regs[8]}));
        chk({o_diag_delay_select, o_active_ol_enable}, {regs[5][6:5], regs[5][2:0]});
    endtask
    initial begin
        regs = '{8'h40, 8'hff, 8'hff, 8'hff};
        repeat (6) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        check_all;
        u_host.wr(6'h04, 8'h5a);
        u_host.rd(6'h04, rv);
        chk(rv, 8'h00);
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            u_host.wr(6'h05 + lfsr[1:0], lfsr[15:8]);
            regs[5 + lfsr[1:0]] = lfsr[15:8];
            if (i % 6 == 5)
                check_all;
        end
        for (int k = 0; k < 16; k++) begin
            u_host.wr(6'h08, {4'(k), 4'(15 - k)});
            regs[8] = {4'(k), 4'(15 - k)};
            repeat (2) @(negedge i_ref_clk);
            chk(o_src_current_half_ma, ma_all({regs[6], regs[7], regs[8]}));
        end
        u_host.wr(6'h05, 8'h40);
        @(posedge i_ref_clk) i_standby <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            u_host.wr(6'h05, {1'b0, 2'(c), 5'h08});
            @(negedge i_ref_clk);
            cycles_to(1'b0, cnt);
            chk(cnt, OLC[c]);
            u_host.poll_idle(ok);
            chk(ok, 1'b1);
        end
        for (int c = 0; c < 4; c++) begin
            u_host.wr(6'h05, 8'h40);
            u_host.wr(6'h05, {1'b0, 2'(c), 5'h10});
            cycles_to(1'b1, cnt);
            cycles_to(1'b1, cnt);
            chk(cnt, SHC[c]);
        end
        u_host.wr(6'h05, 8'h40);
        @(posedge i_ref_clk) i_standby <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            u_host.wr(6'h05, {m[0], 7'h40});
            regs[5] = {m[0], 7'h40};
            @(posedge i_ref_clk) i_overtemp_pin <= 1'b1;
            repeat (10) @(negedge i_ref_clk);
            chk(o_overtemp_fault, 1'b1);
            @(posedge i_ref_clk) i_overtemp_pin <= 1'b0;
            repeat (10) @(negedge i_ref_clk);
            chk(o_overtemp_fault, m == 0);
            @(posedge i_ref_clk) i_clear_fault <= 1'b1;
            @(posedge i_ref_clk) i_clear_fault <= 1'b0;
            repeat (2) @(negedge i_ref_clk);
            chk(o_overtemp_fault, 1'b0);
        end
        check_all;
        report_and_stop;
    end
endmodule // test_gate_drive_diag_config_regs
